//--- design/dbg_params.svh
// Bit positions, reset values and widths of the serial debug register logic
`ifndef DBG_PARAMS_SVH
`define DBG_PARAMS_SVH
`define CTRL_W         8
`define BKPT_W         16
`define BIT_PERMIT     7
`define BIT_ACTIVE     6
`define BIT_BKPT_EN    5
`define BIT_FTS        4
`define BIT_CLKSEL     3
`define BIT_WS         2
`define BIT_WSF        1
`define BIT_DVF        0
`define CTRL_RST       8'h00
`define BKPT_RST       16'h0000
`define DATA_ZERO      16'h0000
`endif

//--- design/dbg_pkg.sv
// Types shared by the serial debug register logic
package dbg_pkg;
   typedef enum logic [2:0] {
      CMD_STATUS_READ,
      CMD_CONTROL_WRITE,
      CMD_BKPT_READ,
      CMD_BKPT_WRITE,
      CMD_HALT,
      CMD_GO,
      CMD_MEM_ACCESS,
      CMD_NONE
   } cmd_e;
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_WAIT_STOP,
      MODE_HALTED
   } mode_e;
endpackage

//--- design/bkpt_if.sv
// Carrier between the debug control logic and its address comparator
`timescale 1ns/1ps
interface bkpt_if #(parameter int AW = 16);
   logic [AW-1:0] cpu_addr;
   logic          cpu_strobe;
   logic          cpu_fetch;
   logic [AW-1:0] match_addr;
   logic          enable;
   logic          force_or_tag_select;
   logic          force_hit;
   logic          tag_hit;
   modport cmp (input cpu_addr, cpu_strobe, cpu_fetch, match_addr, enable, force_or_tag_select, output force_hit, tag_hit);
   modport ctl (output cpu_addr, cpu_strobe, cpu_fetch, match_addr, enable, force_or_tag_select, input force_hit, tag_hit);
endinterface

//--- design/bkpt_compare.sv
// Breakpoint address comparator: splits a match into force and tag hits
`timescale 1ns/1ps
module bkpt_compare
   import dbg_pkg::*;
(
   bkpt_if.cmp bus
);
   logic hit;

   // With the enable clear neither the select bit nor the address has any effect
   assign hit           = bus.enable && bus.cpu_strobe && (bus.cpu_addr == bus.match_addr);
   // Force hit needs no opcode at the address
   assign bus.force_hit = hit && bus.force_or_tag_select;
   // Tag hit only marks an opcode as it is fetched
   assign bus.tag_hit   = hit && !bus.force_or_tag_select && bus.cpu_fetch;
endmodule

//--- design/serial_debug_controller.sv
// Status/control and breakpoint registers of the single-wire serial debug controller
//
// What this block does
// - 8-bit status/control register: status-read command reads it, control-write command writes it.
// - 16-bit breakpoint address register, reached only by breakpoint read/write commands.
// - Neither register has a memory address; CPU accesses never reach them.
// - Halt-permit bit cannot be written while the CPU is halted in debug mode.
// - Active, wait/stop, failure and slow-access bits are read-only to control writes.
// - Bit 7 permits halted mode; once set it stays set until reset.
// - Bit 6 reads 1 while halted in debug mode, 0 while running.
// - Bit 5 clear disables breakpoint; select bit and address then have no effect.
// - Bit 4 set: address match forces halt at next instruction boundary.
// - Bit 4 clear: match tags the opcode; halt when it reaches queue end.
// - Bit 3 selects link clock, 0 alternate source, 1 bus clock; always writable.
// - Bit 2 reads 1 in wait/stop, or after halt command left wait/stop.
// - Halt command moves the CPU from wait/stop into halted debug mode.
// - Most serial commands are refused while the CPU is in wait or stop.
// - Bit 1 sets when a memory command fails against a wait/stop.
// - Bit 0 reports slow-memory failures; no slow memory, so it stays 0.
// - Breakpoint without halt permission runs a software interrupt instead.
`timescale 1ns/1ps
`include "dbg_params.svh"
module serial_debug_controller
   import dbg_pkg::*;
#(
   parameter int AW = `BKPT_W
)
(
   input  wire logic          CORE_CLK,
   input  wire logic          SRST,
   input  wire logic          CMD_VALID,
   input  wire cmd_e          CMD_CODE,
   input  wire logic [15:0]   CMD_WDATA,
   output logic               RSP_VALID,
   output logic               CMD_REFUSED,
   output logic [15:0]        RSP_DATA,
   output logic               MEM_GO,
   input  wire logic [AW-1:0] CPU_ADDR,
   input  wire logic          CPU_ADDR_STROBE,
   input  wire logic          CPU_OPCODE_FETCH,
   input  wire logic          CPU_BOUNDARY,
   input  wire logic          CPU_TAG_END,
   input  wire logic          CPU_WAIT_STOP,
   output logic               TAG_REQ,
   output logic               SWI_REQ,
   output logic               DEBUG_HALT_ACTIVE,
   output logic               LINK_CLOCK_SELECT
);
   typedef struct packed {
      mode_e         mode;
      logic          permit;
      logic          bkpt_enable;
      logic          force_or_tag_select;
      logic          clksel;
      logic          ws_hist;
      logic          wait_stop_failure_flag;
      logic [AW-1:0] bkpt_addr;
      logic          force_pend;
      logic          rsp_valid;
      logic          refused;
      logic [15:0]   rsp_data;
      logic          mem_go;
      logic          tag_req;
      logic          swi_req;
   } state_s;

   state_s            q;
   state_s            d;
   logic [`CTRL_W-1:0] status_byte;
   logic              active;
   logic              in_ws;
   logic              bkpt_req;
   logic              ws_ok;

   bkpt_if #(.AW(AW)) bk ();

   assign bk.cpu_addr   = CPU_ADDR;
   assign bk.cpu_strobe = CPU_ADDR_STROBE;
   assign bk.cpu_fetch  = CPU_OPCODE_FETCH;
   assign bk.match_addr = q.bkpt_addr;
   assign bk.enable     = q.bkpt_enable && (q.mode == MODE_RUN);
   assign bk.force_or_tag_select        = q.force_or_tag_select;

   bkpt_compare u_cmp (
      .bus (bk.cmp)
   );

   assign active = (q.mode == MODE_HALTED);
   assign in_ws  = (q.mode == MODE_WAIT_STOP);

   // Status view; slow-access bit is tied low since there is no slow memory
   always_comb
   begin
      status_byte               = `CTRL_RST;
      status_byte[`BIT_PERMIT]  = q.permit;
      status_byte[`BIT_ACTIVE]  = active;
      status_byte[`BIT_BKPT_EN] = q.bkpt_enable;
      status_byte[`BIT_FTS]     = q.force_or_tag_select;
      status_byte[`BIT_CLKSEL]  = q.clksel;
      status_byte[`BIT_WS]      = in_ws || q.ws_hist;
      status_byte[`BIT_WSF]     = q.wait_stop_failure_flag;
      status_byte[`BIT_DVF]     = 1'b0;
   end

   // Commands that still work in wait/stop: status, control and halt
   assign ws_ok = (CMD_CODE == CMD_STATUS_READ) || (CMD_CODE == CMD_CONTROL_WRITE) || (CMD_CODE == CMD_HALT);

   // A breakpoint event that wants the CPU halted this cycle
   assign bkpt_req = (q.mode == MODE_RUN) && ((q.force_pend && CPU_BOUNDARY) || CPU_TAG_END);

   always_comb
   begin
      d           = q;
      d.rsp_valid = 1'b0;
      d.refused   = 1'b0;
      d.mem_go    = 1'b0;
      d.tag_req   = bk.tag_hit;
      d.swi_req   = 1'b0;

      // Wait/stop follows the CPU unless halted debug mode owns it
      unique case (q.mode)
         MODE_RUN:
         begin
            if (CPU_WAIT_STOP)
               d.mode = MODE_WAIT_STOP;
         end
         MODE_WAIT_STOP:
         begin
            if (!CPU_WAIT_STOP)
               d.mode = MODE_RUN;
         end
         MODE_HALTED:
         begin
         end
         // The fourth code of the mode field is never entered; fall back to run
         default:
         begin
            d.mode = MODE_RUN;
         end
      endcase

      // Force match is held until the current instruction finishes
      if (bk.force_hit)
         d.force_pend = 1'b1;
      if (bkpt_req)
      begin
         d.force_pend = 1'b0;
         if (q.permit)
            d.mode = MODE_HALTED;
         else
            d.swi_req = 1'b1;
      end

      if (CMD_VALID)
      begin
         if (in_ws && !ws_ok)
         begin
            d.refused = 1'b1;
            // Memory command colliding with wait/stop is logged
            if (CMD_CODE == CMD_MEM_ACCESS)
               d.wait_stop_failure_flag = 1'b1;
         end
         else
         begin
            d.rsp_valid = 1'b1;
            unique case (CMD_CODE)
               CMD_STATUS_READ:
               begin
                  d.rsp_data = {8'h00, status_byte};
               end
               CMD_CONTROL_WRITE:
               begin
                  // Permit only sets, and never while halted
                  if (!active && CMD_WDATA[`BIT_PERMIT])
                     d.permit = 1'b1;
                  d.bkpt_enable = CMD_WDATA[`BIT_BKPT_EN];
                  d.force_or_tag_select         = CMD_WDATA[`BIT_FTS];
                  d.clksel      = CMD_WDATA[`BIT_CLKSEL];
                  // Status bits of the write data are dropped without complaint
               end
               CMD_BKPT_READ:
               begin
                  d.rsp_data = 16'(q.bkpt_addr);
               end
               CMD_BKPT_WRITE:
               begin
                  d.bkpt_addr = CMD_WDATA[AW-1:0];
               end
               CMD_HALT:
               begin
                  if (q.permit)
                  begin
                     d.mode       = MODE_HALTED;
                     d.force_pend = 1'b0;
                     if (in_ws)
                        d.ws_hist = 1'b1;
                  end
                  else
                  begin
                     d.rsp_valid = 1'b0;
                     d.refused   = 1'b1;
                  end
               end
               CMD_GO:
               begin
                  if (active)
                  begin
                     d.mode    = MODE_RUN;
                     d.ws_hist = 1'b0;
                  end
                  else
                  begin
                     d.rsp_valid = 1'b0;
                     d.refused   = 1'b1;
                  end
               end
               CMD_MEM_ACCESS:
               begin
                  // A good access retires an earlier failure; no failure can be logged in the same cycle
                  d.mem_go = 1'b1;
                  d.wait_stop_failure_flag    = 1'b0;
               end
               CMD_NONE:
               begin
                  d.rsp_valid = 1'b0;
                  d.refused   = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         q.mode        <= MODE_RUN;
         q.permit      <= 1'b0;
         q.bkpt_enable <= 1'b0;
         q.force_or_tag_select         <= 1'b0;
         q.clksel      <= 1'b0;
         q.ws_hist     <= 1'b0;
         q.wait_stop_failure_flag         <= 1'b0;
         q.bkpt_addr   <= `BKPT_RST;
         q.force_pend  <= 1'b0;
         q.rsp_valid   <= 1'b0;
         q.refused     <= 1'b0;
         q.rsp_data    <= `DATA_ZERO;
         q.mem_go      <= 1'b0;
         q.tag_req     <= 1'b0;
         q.swi_req     <= 1'b0;
      end
      else
         q <= d;
   end

   // No memory-mapped path exists: writable bits change only via commands
   assign RSP_VALID         = q.rsp_valid;
   assign CMD_REFUSED       = q.refused;
   assign RSP_DATA          = q.rsp_data;
   assign MEM_GO            = q.mem_go;
   assign TAG_REQ           = q.tag_req;
   assign SWI_REQ           = q.swi_req;
   assign DEBUG_HALT_ACTIVE = active;
   assign LINK_CLOCK_SELECT = q.clksel;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   // Register protection
   a_permit_sticky: assert property (q.permit |=> q.permit)
      else $error("halt permit fell without reset");
   a_permit_halted: assert property (active && !q.permit |=> !q.permit)
      else $error("halt permit written while halted");
   a_permit_set: assert property (CMD_VALID && CMD_CODE == CMD_CONTROL_WRITE && CMD_WDATA[`BIT_PERMIT]
                                  && !active |=> q.permit)
      else $error("halt permit not set by control write");
   a_ro_status: assert property (CMD_VALID && CMD_CODE == CMD_CONTROL_WRITE && !CPU_WAIT_STOP
                                 && !in_ws && !bkpt_req
                                 |=> q.wait_stop_failure_flag == $past(q.wait_stop_failure_flag) && q.ws_hist == $past(q.ws_hist)
                                     && q.mode == $past(q.mode))
      else $error("control write moved a status bit");
   a_ctrl_write: assert property (CMD_VALID && CMD_CODE == CMD_CONTROL_WRITE
                                  |=> q.force_or_tag_select == $past(CMD_WDATA[`BIT_FTS])
                                      && q.bkpt_enable == $past(CMD_WDATA[`BIT_BKPT_EN]))
      else $error("control write not stored");
   a_clock_select: assert property (CMD_VALID && CMD_CODE == CMD_CONTROL_WRITE
                                    |=> LINK_CLOCK_SELECT == $past(CMD_WDATA[`BIT_CLKSEL]))
      else $error("link clock select not written");

   // Command answers
   a_one_answer: assert property (CMD_VALID |=> RSP_VALID != CMD_REFUSED)
      else $error("command answered twice or not at all");
   a_status_read: assert property (CMD_VALID && CMD_CODE == CMD_STATUS_READ
                                   |=> RSP_VALID && RSP_DATA[`BIT_ACTIVE] == $past(active))
      else $error("status read wrong");
   a_dvf_zero: assert property (CMD_VALID && CMD_CODE == CMD_STATUS_READ |=> RSP_DATA[`BIT_DVF] == 1'b0)
      else $error("slow access flag set");
   a_bkpt_rw: assert property (CMD_VALID && CMD_CODE == CMD_BKPT_WRITE && !in_ws
                               ##1 CMD_VALID && CMD_CODE == CMD_BKPT_READ && !in_ws
                               |=> RSP_DATA == $past(CMD_WDATA, 2))
      else $error("breakpoint readback mismatch");
   // The host leaves one idle cycle between commands, so this form is the one a session meets
   a_bkpt_gap: assert property (CMD_VALID && CMD_CODE == CMD_BKPT_WRITE && !in_ws
                                ##1 !CMD_VALID
                                ##1 CMD_VALID && CMD_CODE == CMD_BKPT_READ && !in_ws
                                |=> RSP_DATA == $past(CMD_WDATA, 3))
      else $error("breakpoint readback after idle cycle mismatch");
   a_halt_permit: assert property (CMD_VALID && CMD_CODE == CMD_HALT && !q.permit |=> CMD_REFUSED && !active)
      else $error("halt served without permit");
   a_mem_go: assert property (CMD_VALID && CMD_CODE == CMD_MEM_ACCESS && !in_ws |=> MEM_GO && !q.wait_stop_failure_flag)
      else $error("memory command not released");
   a_go_resume: assert property (CMD_VALID && CMD_CODE == CMD_GO && active |=> !DEBUG_HALT_ACTIVE)
      else $error("go command did not resume");

   // Breakpoint path
   a_bkpt_off: assert property (!q.bkpt_enable |-> !bk.force_hit && !bk.tag_hit)
      else $error("breakpoint hit while disabled");
   a_tag_mark: assert property (CPU_ADDR_STROBE && CPU_OPCODE_FETCH && CPU_ADDR == q.bkpt_addr
                                && q.bkpt_enable && !q.force_or_tag_select && q.mode == MODE_RUN |=> TAG_REQ)
      else $error("fetched opcode at breakpoint not tagged");
   a_force_pend: assert property (CPU_ADDR_STROBE && CPU_ADDR == q.bkpt_addr && q.bkpt_enable && q.force_or_tag_select
                                  && q.mode == MODE_RUN && !CPU_BOUNDARY && !CPU_TAG_END && !CMD_VALID
                                  |=> q.force_pend)
      else $error("force match not held");
   a_force_halt: assert property (q.permit && q.mode == MODE_RUN && q.force_pend && CPU_BOUNDARY
                                  |=> DEBUG_HALT_ACTIVE)
      else $error("force breakpoint did not halt");
   a_tag_halt: assert property (q.permit && q.mode == MODE_RUN && CPU_TAG_END |=> DEBUG_HALT_ACTIVE)
      else $error("tagged opcode did not halt");
   a_swi_instead: assert property (!q.permit && bkpt_req |=> SWI_REQ && !DEBUG_HALT_ACTIVE)
      else $error("missing software interrupt");

   // Wait and stop
   a_ws_refuse: assert property (in_ws && CMD_VALID && !ws_ok |=> CMD_REFUSED && !RSP_VALID)
      else $error("command served during wait/stop");
   a_wsf_set: assert property (in_ws && CMD_VALID && CMD_CODE == CMD_MEM_ACCESS |=> status_byte[`BIT_WSF])
      else $error("wait/stop failure not flagged");
   a_halt_ws: assert property (in_ws && q.permit && CMD_VALID && CMD_CODE == CMD_HALT
                               |=> active && status_byte[`BIT_WS])
      else $error("halt from wait/stop lost status");

   c_force_halt: cover property (q.force_pend && CPU_BOUNDARY ##1 active);
   c_tag_halt:   cover property (CPU_TAG_END && q.permit ##1 active);
   c_ws_halt:    cover property (in_ws ##1 CMD_VALID && CMD_CODE == CMD_HALT ##1 active);
   c_ws_fail:    cover property (in_ws && CMD_VALID && CMD_CODE == CMD_MEM_ACCESS ##1 CMD_REFUSED);
   c_swi:        cover property (SWI_REQ);
endmodule

//--- dv/dbg_host.sv
// Debug host model: issues serial debug commands one at a time
`timescale 1ns/1ps
module dbg_host
   import dbg_pkg::*;
(
   input  wire logic        clk,
   output logic             cmd_valid,
   output cmd_e             cmd_code,
   output logic [15:0]      cmd_wdata,
   input  wire logic        rsp_valid,
   input  wire logic        rsp_refused,
   input  wire logic [15:0] rsp_data
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code  = CMD_NONE;
      cmd_wdata = 16'h0000;
   end
   // One command per call; the answer stands from the taking edge and is read 1 ns after it
   task automatic send(input cmd_e code, input logic [15:0] wd, output logic [1:0] acc, output logic [15:0] rd);
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_code  = code;
      cmd_wdata = wd;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      cmd_code  = CMD_NONE;
      // Released data shows the inverse so a stale copy cannot pass
      cmd_wdata = ~wd;
      acc       = {rsp_valid, rsp_refused};
      rd        = rsp_data;
   endtask
endmodule

//--- dv/serial_debug_controller_tb.sv
// Self-checking bench for the serial debug register logic
`timescale 1ns/1ps
`include "dbg_params.svh"
module serial_debug_controller_tb
   import dbg_pkg::*;
;
   logic        clk, srst, cmd_valid, rsp_valid, cmd_refused, mem_go, tag_req, swi_req, halt_act, link_sel;
   logic        strobe, fetch, boundary, tag_end, wait_stop;
   cmd_e        cmd_code;
   logic [15:0] cmd_wdata, rsp_data, cpu_addr, rd, a;
   logic [1:0]  acc;
   logic [7:0]  ctl;
   logic [31:0] seed;
   int          mismatches, check_count;

   dbg_host i_dbg_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid), .rsp_refused(cmd_refused), .rsp_data(rsp_data));

   serial_debug_controller i_serial_debug_controller (.CORE_CLK(clk), .SRST(srst), .CMD_VALID(cmd_valid),
      .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .CMD_REFUSED(cmd_refused),
      .RSP_DATA(rsp_data), .MEM_GO(mem_go), .CPU_ADDR(cpu_addr), .CPU_ADDR_STROBE(strobe),
      .CPU_OPCODE_FETCH(fetch), .CPU_BOUNDARY(boundary), .CPU_TAG_END(tag_end), .CPU_WAIT_STOP(wait_stop),
      .TAG_REQ(tag_req), .SWI_REQ(swi_req), .DEBUG_HALT_ACTIVE(halt_act), .LINK_CLOCK_SELECT(link_sel));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   // Permit is sticky; the low three bits are status and never written
   function automatic logic [7:0] ctl_after(input logic [7:0] c, input logic [7:0] w);
      return {c[7] | w[7], 1'b0, w[5:3], 3'b000};
   endfunction
   function automatic logic [7:0] status(input logic [7:0] c, input logic act, input logic ws, input logic wait_stop_failure_flag);
      return {c[7], act, c[5:3], ws, wait_stop_failure_flag, 1'b0};
   endfunction

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk1(input logic seen, input logic exp);
      chk({15'h0000, seen}, {15'h0000, exp});
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic cmd(input cmd_e c, input logic [15:0] wd, input logic [1:0] eacc);
      i_dbg_host.send(c, wd, acc, rd);
      chk({14'h0000, acc}, {14'h0000, eacc});
   endtask
   task automatic wctl(input logic [7:0] w);
      cmd(CMD_CONTROL_WRITE, {rnd() & 16'hFF00} | {8'h00, w}, 2'b10);
      ctl = ctl_after(ctl, w);
   endtask
   task automatic rstat(input logic act, input logic ws, input logic wait_stop_failure_flag);
      cmd(CMD_STATUS_READ, rnd(), 2'b10);
      chk(rd, {8'h00, status(ctl, act, ws, wait_stop_failure_flag)});
   endtask
   task automatic hit(input logic [15:0] ad, input logic f);
      strobe   = 1'b1;
      fetch    = f;
      cpu_addr = ad;
      step;
      strobe   = 1'b0;
      fetch    = 1'b0;
      cpu_addr = rnd();
   endtask
   task automatic bound;
      boundary = 1'b1;
      step;
      boundary = 1'b0;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out;
   end

   initial
   begin
      mismatches  = 0;
      check_count = 0;
      seed = 52151;
      ctl  = `CTRL_RST;
      srst = 1'b1;
      {strobe, fetch, boundary, tag_end, wait_stop} = 5'h00;
      cpu_addr = 16'h0000;
      repeat (12) @(posedge clk);
      #1;
      srst = 1'b0;
      rstat(1'b0, 1'b0, 1'b0);
      cmd(CMD_BKPT_READ, rnd(), 2'b10);
      chk(rd, `BKPT_RST);
      cmd(CMD_HALT, rnd(), 2'b01);
      wctl(8'h7F);
      rstat(1'b0, 1'b0, 1'b0);
      chk1(link_sel, 1'b1);
      wctl(8'h80);
      wctl(8'h00);
      rstat(1'b0, 1'b0, 1'b0);
      chk1(link_sel, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         a = rnd();
         cmd(CMD_BKPT_WRITE, a, 2'b10);
         cmd(CMD_BKPT_READ, rnd(), 2'b10);
         chk(rd, a);
      end
      // Force type: a near miss first, then the exact address
      wctl(8'hB0);
      hit(a ^ 16'h0001, 1'b0);
      bound;
      chk1(halt_act, 1'b0);
      hit(a, 1'b0);
      bound;
      chk1(halt_act, 1'b1);
      rstat(1'b1, 1'b0, 1'b0);
      wctl(8'h3F);
      rstat(1'b1, 1'b0, 1'b0);
      cmd(CMD_GO, rnd(), 2'b10);
      step;
      chk1(halt_act, 1'b0);
      // Tag type: halt only when the tagged opcode reaches the end
      wctl(8'hA0);
      hit(a, 1'b1);
      chk1(tag_req, 1'b1);
      chk1(halt_act, 1'b0);
      tag_end = 1'b1;
      step;
      tag_end = 1'b0;
      chk1(halt_act, 1'b1);
      cmd(CMD_GO, rnd(), 2'b10);
      // Disabled breakpoint: tag select first, then force select
      wctl(8'h80);
      hit(a, 1'b1);
      chk1(tag_req, 1'b0);
      wctl(8'h90);
      hit(a, 1'b0);
      bound;
      chk1(halt_act, 1'b0);
      // Wait/stop: refusals, failure flag, halt out of it, recovery
      wait_stop = 1'b1;
      cmd(CMD_BKPT_READ, rnd(), 2'b01);
      cmd(CMD_MEM_ACCESS, rnd(), 2'b01);
      chk1(mem_go, 1'b0);
      rstat(1'b0, 1'b1, 1'b1);
      cmd(CMD_HALT, rnd(), 2'b10);
      wait_stop = 1'b0;
      rstat(1'b1, 1'b1, 1'b1);
      cmd(CMD_MEM_ACCESS, rnd(), 2'b10);
      chk1(mem_go, 1'b1);
      rstat(1'b1, 1'b1, 1'b0);
      cmd(CMD_GO, rnd(), 2'b10);
      rstat(1'b0, 1'b0, 1'b0);
      // Without permit a breakpoint becomes a software interrupt
      srst = 1'b1;
      step;
      srst = 1'b0;
      ctl  = `CTRL_RST;
      wctl(8'h30);
      cmd(CMD_BKPT_WRITE, a, 2'b10);
      hit(a, 1'b0);
      bound;
      chk1(swi_req, 1'b1);
      chk1(halt_act, 1'b0);
      close_out;
   end
endmodule
